/* verilog/occ_params.svh */
// Purpose: offsets, field positions, write mask for the compare channel
// Assumes: APB, 32-bit data, one word per register
// Notes: definitions only
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
`define OCC_ADDR_CTRL 12'h000
`define OCC_ADDR_PRI 12'h004
`define OCC_ADDR_SEC 12'h008
`define OCC_ADDR_STAT 12'h00c
`define OCC_ADDR_CLR 12'h010
`define OCC_ADDR_IEN 12'h014
`define OCC_CTRL_WMASK 16'h200f
`define OCC_BIT_IDLE 13
`define OCC_BIT_FLT 4
`define OCC_BIT_TSEL 3
`define OCC_MODE_MSB 2
`define OCC_EV_MATCH 0
`define OCC_EV_PIN 1
`define OCC_EV_FAULT 2
`define OCC_NEV 3
`endif

/* verilog/occ_pkg.sv */
// Purpose: types for the compare channel
// Assumes: nothing
// Notes: mode codes follow the control field
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_OFF = 3'b000,
    OCC_RISE1 = 3'b001,
    OCC_FALL1 = 3'b010,
    OCC_TOGGLE = 3'b011,
    OCC_PULSE1 = 3'b100,
    OCC_PULSEN = 3'b101,
    OCC_PWM = 3'b110,
    OCC_PWMF = 3'b111
  } occ_mode_t;
  typedef struct packed {
    logic idleStop;
    logic timeSel;
    occ_mode_t mode;
  } occ_cfg_t;
  typedef struct packed {
    logic [15:0] timerA;
    logic [15:0] timerB;
    logic periodA;
    logic periodB;
  } occ_tb_t;
endpackage

/* verilog/occ_edge.sv */
// Purpose: one-cycle edge pulses of a level
// Assumes: input synchronous to core_clk
// Notes: reset value is a parameter
`timescale 1ns/10ps
module occ_edge #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // level and edges
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_r <= INIT;
    end else begin
      prev_r <= level;
    end
  end
  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule

/* verilog/occ_irq.sv */
// Purpose: sticky event status, enable and clear, one level interrupt
// Assumes: set wins over clear
// Notes: generate loop per event bit
`timescale 1ns/10ps
module occ_irq #(
  parameter int N = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // events and software
  input wire logic [N-1:0] evt,
  input wire logic [N-1:0] clrBits,
  input wire logic clrWr,
  input wire logic [N-1:0] enable,
  // results
  output logic [N-1:0] status,
  output logic irq
);
  logic [N-1:0] stat_r;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gBit
      always_ff @(posedge core_clk) begin
        if (srst) begin
          stat_r[g] <= 1'b0;
        end else if (evt[g]) begin
          stat_r[g] <= 1'b1;
        end else if (clrWr && clrBits[g]) begin
          stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((stat_r | evt) & enable);
    end
  end
  assign status = stat_r;
endmodule

/* verilog/occ_channel.sv */
// Purpose: one output compare channel with APB registers
// Assumes: timers and period flags come from outside, synchronous to core_clk
// Notes: pin is two signals; the pad resolves the level
// Summary of operation
// - time base select 1 picks second timer, 0 picks first timer
// - compare against one or two compare registers per mode
// - pin changes on timer equal compare, and in PWM also at the period and on fault; match may interrupt
// - mode 000 disables channel, no interrupt, pin left to GPIO
// - mode 001 starts pin low, match drives high, rising edge interrupts
// - mode 010 starts pin high, match drives low, falling edge interrupts
// - mode 011 keeps level, match toggles, both edges interrupt
// - mode 100 starts low, one single pulse, falling edge interrupts
// - mode 101 starts low, continuous pulses, each falling edge interrupts
// - mode 110 PWM without fault, init from primary nonzero, no interrupt
// - mode 111 PWM with fault, same init, fault falling edge interrupts
// - fault input a governs channels 1-4, fault input b 5-8
// - fault flag reads 1 after PWM fault, read-only, hardware cleared
// - idle stop bit set halts channel in CPU idle
`timescale 1ns/10ps
`include "occ_params.svh"
module occ_channel import occ_pkg::*; #(
  parameter int CHANNEL = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // time base and system state
  input wire occ_tb_t timeBase,
  input wire logic cpuIdle,
  // fault inputs, active low
  input wire logic faultInputA,
  input wire logic faultInputB,
  // output pin and interrupt
  output logic pinOut,
  output logic pinOe,
  output logic irq
);
  occ_cfg_t cfg_r;
  logic fltFlag_r;
  logic [15:0] priCmp_r;
  logic [15:0] secCmp_r;
  logic pin_r;
  logic oe_r;
  logic done_r;
  logic halted_r;
  logic [`OCC_NEV-1:0] ien_r;
  logic [`OCC_NEV-1:0] stat;
  logic irqRaw;
  logic [15:0] timer;
  logic period;
  logic running;
  logic matchPri;
  logic matchSec;
  logic fault;
  logic pinRise;
  logic pinFall;
  logic fltFall;
  logic modeWr;
  logic acc;
  // decoded strobes
  logic setup;
  logic wrPri;
  logic wrSec;
  logic wrClr;
  logic wrIen;
  occ_mode_t newMode;
  logic [15:0] ctrlWord;
  logic [`OCC_NEV-1:0] evt;
  logic pin_nxt;
  logic isPwm;

  // apb register decode; writes land on the access edge
  assign acc = psel & penable;
  assign setup = psel & ~penable;
  assign modeWr = acc & pwrite & (paddr == `OCC_ADDR_CTRL);
  assign wrPri = acc & pwrite & (paddr == `OCC_ADDR_PRI);
  assign wrSec = acc & pwrite & (paddr == `OCC_ADDR_SEC);
  assign wrClr = acc & pwrite & (paddr == `OCC_ADDR_CLR);
  assign wrIen = acc & pwrite & (paddr == `OCC_ADDR_IEN);
  assign newMode = occ_mode_t'(pwdata[`OCC_MODE_MSB:0]);
  assign isPwm = cfg_r.mode[`OCC_MODE_MSB] & cfg_r.mode[1];
  // control word as software reads it; unimplemented bits read zero
  assign ctrlWord = {2'h0, cfg_r.idleStop, 8'h00, fltFlag_r, cfg_r.timeSel, cfg_r.mode};

  // selected time base and compare matches
  assign timer = cfg_r.timeSel ? timeBase.timerB : timeBase.timerA;
  assign period = cfg_r.timeSel ? timeBase.periodB : timeBase.periodA;
  assign running = (cfg_r.mode != OCC_OFF) && !halted_r;
  assign matchPri = running && (timer == priCmp_r);
  assign matchSec = running && (timer == secCmp_r);
  assign fault = (CHANNEL <= 4) ? faultInputA : faultInputB;

  // idle halt, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halted_r <= 1'b0;
    end else begin
      halted_r <= cpuIdle & cfg_r.idleStop;
    end
  end

  // control register, software side
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_r <= '{1'b0, 1'b0, OCC_OFF};
    end else if (modeWr) begin
      cfg_r.idleStop <= pwdata[`OCC_BIT_IDLE];
      cfg_r.timeSel <= pwdata[`OCC_BIT_TSEL];
      cfg_r.mode <= newMode;
    end
  end

  // secondary compare register, software side
  always_ff @(posedge core_clk) begin
    if (srst) begin
      secCmp_r <= 16'h0000;
    end else if (wrSec) begin
      secCmp_r <= pwdata[15:0];
    end
  end

  // primary compare; PWM reloads it from secondary at the period
  always_ff @(posedge core_clk) begin
    if (srst) begin
      priCmp_r <= 16'h0000;
    end else if (wrPri) begin
      priCmp_r <= pwdata[15:0];
    end else if (running && isPwm && period) begin
      priCmp_r <= secCmp_r;
    end
  end

  // fault flag, cleared only by hardware on a mode rewrite
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fltFlag_r <= 1'b0;
    end else if (running && cfg_r.mode == OCC_PWMF && !fault) begin
      fltFlag_r <= 1'b1;
    end else if (modeWr) begin
      fltFlag_r <= 1'b0;
    end
  end

  // pin next value
  always_comb begin
    pin_nxt = pin_r;
    case (cfg_r.mode)
      OCC_OFF: pin_nxt = pin_r;
      OCC_RISE1: if (matchPri) pin_nxt = 1'b1;
      OCC_FALL1: if (matchPri) pin_nxt = 1'b0;
      OCC_TOGGLE: if (matchPri) pin_nxt = ~pin_r;
      OCC_PULSE1, OCC_PULSEN: begin
        if (matchSec && pin_r) begin
          pin_nxt = 1'b0;
        end else if (matchPri && !done_r) begin
          pin_nxt = 1'b1;
        end
      end
      OCC_PWM, OCC_PWMF: begin
        if (running && period) begin
          pin_nxt = (secCmp_r != 16'h0000);
        end else if (matchPri) begin
          pin_nxt = 1'b0;
        end
        if (cfg_r.mode == OCC_PWMF && (fltFlag_r || (running && !fault))) begin
          pin_nxt = 1'b0;
        end
      end
      default: pin_nxt = pin_r;
    endcase
  end

  // pin drive; mode write sets the initial level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
      done_r <= 1'b0;
    end else if (modeWr) begin
      done_r <= 1'b0;
      oe_r <= (newMode != OCC_OFF);
      case (newMode)
        OCC_FALL1: pin_r <= 1'b1;
        OCC_TOGGLE: pin_r <= pin_r;
        OCC_PWM, OCC_PWMF: pin_r <= (priCmp_r != 16'h0000);
        default: pin_r <= 1'b0;
      endcase
    end else if (running) begin
      pin_r <= pin_nxt;
      if (cfg_r.mode == OCC_PULSE1 && pinFall) begin
        done_r <= 1'b1;
      end
      if (cfg_r.mode == OCC_PWMF && !fault) begin
        oe_r <= 1'b0;
      end
    end
  end

  occ_edge #(.INIT(1'b0)) uPinEdge (
    .core_clk(core_clk),
    .srst(srst),
    .level(pin_r),
    .rise(pinRise),
    .fall(pinFall)
  );

  occ_edge #(.INIT(1'b1)) uFltEdge (
    .core_clk(core_clk),
    .srst(srst),
    .level(fault),
    .rise(),
    .fall(fltFall)
  );

  // interrupt events per mode
  always_comb begin
    evt = '0;
    evt[`OCC_EV_MATCH] = matchPri & ~isPwm;
    case (cfg_r.mode)
      OCC_RISE1: evt[`OCC_EV_PIN] = pinRise;
      OCC_FALL1, OCC_PULSE1, OCC_PULSEN: evt[`OCC_EV_PIN] = pinFall;
      OCC_TOGGLE: evt[`OCC_EV_PIN] = pinRise | pinFall;
      OCC_PWMF: evt[`OCC_EV_FAULT] = fltFall & running;
      default: evt = '0;
    endcase
  end

  occ_irq #(.N(`OCC_NEV)) uIrq (
    .core_clk(core_clk),
    .srst(srst),
    .evt(evt),
    .clrBits(pwdata[`OCC_NEV-1:0]),
    .clrWr(wrClr),
    .enable(ien_r),
    .status(stat),
    .irq(irqRaw)
  );

  // interrupt enable register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ien_r <= '0;
    end else if (wrIen) begin
      ien_r <= pwdata[`OCC_NEV-1:0];
    end
  end

  // apb answer, zero wait, unmapped gives slverr
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (setup) begin
        case (paddr)
          `OCC_ADDR_CTRL: prdata <= {16'h0000, ctrlWord};
          `OCC_ADDR_PRI: prdata <= {16'h0000, priCmp_r};
          `OCC_ADDR_SEC: prdata <= {16'h0000, secCmp_r};
          `OCC_ADDR_STAT: prdata <= {29'h0, stat};
          `OCC_ADDR_CLR: prdata <= 32'h00000000;
          `OCC_ADDR_IEN: prdata <= {29'h0, ien_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // registered pin outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      pinOut <= pin_r;
      pinOe <= oe_r;
    end
  end

  // registered interrupt output
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= irqRaw;
    end
  end
endmodule

/* dv/occ_channel_checker.sv */
// Purpose: port assertions for the compare channel
// Assumes: CHANNEL 1, so fault input a governs
// Notes: shadows software writes
`timescale 1ns/10ps
module occ_channel_checker import occ_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // time base, faults, pin
  input wire occ_tb_t timeBase,
  input wire logic cpuIdle,
  input wire logic faultInputA,
  input wire logic faultInputB,
  input wire logic pinOut,
  input wire logic pinOe
);
  logic [15:0] ctrl_r;
  logic [15:0] pri_r;
  logic [15:0] sec_r;
  logic wr;
  logic [15:0] selTimer;
  logic selPeriod;
  assign wr = psel && penable && pwrite && pready;
  assign selTimer = ctrl_r[3] ? timeBase.timerB : timeBase.timerA;
  assign selPeriod = ctrl_r[3] ? timeBase.periodB : timeBase.periodA;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r <= 16'h0000;
      pri_r <= 16'h0000;
      sec_r <= 16'h0000;
    end else if (wr) begin
      if (paddr == 12'h000) ctrl_r <= pwdata[15:0];
      if (paddr == 12'h004) pri_r <= pwdata[15:0];
      if (paddr == 12'h008) sec_r <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_mode(logic [2:0] m);
    (ctrl_r[2:0] == m)[*4];
  endsequence
  property p_off; s_mode(3'h0) |-> !pinOe; endproperty
  a_off: assert property (p_off) else $error("pin driven while off");
  property p_rise; s_mode(3'h1) |-> !$fell(pinOut); endproperty
  a_rise: assert property (p_rise) else $error("pin fell in mode 1");
  property p_fall; s_mode(3'h2) |-> !$rose(pinOut); endproperty
  a_fall: assert property (p_fall) else $error("pin rose in mode 2");
  property p_match; s_mode(3'h1) ##0 $rose(pinOut) |-> $past(selTimer, 2) == pri_r; endproperty
  a_match: assert property (p_match) else $error("pin moved without match");
  property p_pwm; s_mode(3'h6) ##0 (selPeriod && sec_r != 16'h0000) |-> ##2 pinOut; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm period not high");
  property p_flt; s_mode(3'h7) ##0 $fell(faultInputA) |-> ##[1:3] (!pinOe && !pinOut); endproperty
  a_flt: assert property (p_flt) else $error("fault did not release pin");
  property p_fltb; s_mode(3'h7) ##0 (faultInputA && pinOe && $fell(faultInputB)) |=> pinOe[*3];
  endproperty
  a_fltb: assert property (p_fltb) else $error("wrong fault input used");
  property p_idle; (ctrl_r[13] && cpuIdle)[*3] |-> $stable(pinOut); endproperty
  a_idle: assert property (p_idle) else $error("pin moved in idle");
endmodule
bind occ_channel occ_channel_checker i_chk (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .timeBase(timeBase), .cpuIdle(cpuIdle), .faultInputA(faultInputA),
  .faultInputB(faultInputB), .pinOut(pinOut), .pinOe(pinOe));

/* dv/occ_pad_model.sv */
// Purpose: pad and fault circuitry around the compare pin
// Assumes: pad pulled low, fault lines pulled high
// Notes: bench requests faults
`timescale 1ns/10ps
module occ_pad_model (
  // pin side
  input wire logic pinOut,
  input wire logic pinOe,
  output logic padLevel,
  // fault side
  input wire logic faultReqA,
  input wire logic faultReqB,
  output logic faultInputA,
  output logic faultInputB
);
  assign padLevel = pinOe ? pinOut : 1'b0;
  assign faultInputA = !faultReqA;
  assign faultInputB = !faultReqB;
endmodule

/* dv/occ_channel_test.sv */
// Purpose: self-checking bench for the compare channel
// Assumes: CHANNEL 1, compare 4 and 8, period 16
// Notes: timers stopped while control is written
`timescale 1ns/10ps
module occ_channel_test import occ_pkg::*; ;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, pinOut, pinOe, irq, padLevel, faultInputA, faultInputB;
  occ_tb_t timeBase = '0;
  logic cpuIdle = 1'b1;
  logic faultReqA = 1'b0;
  logic faultReqB = 1'b0;
  logic [31:0] rd;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  always #25 core_clk = ~core_clk;
  occ_channel #(.CHANNEL(1)) i_dut (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timeBase(timeBase), .cpuIdle(cpuIdle),
    .faultInputA(faultInputA), .faultInputB(faultInputB), .pinOut(pinOut), .pinOe(pinOe),
    .irq(irq));
  occ_pad_model i_pad (.pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel),
    .faultReqA(faultReqA), .faultReqB(faultReqB), .faultInputA(faultInputA),
    .faultInputB(faultInputB));
  task automatic test_done;
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", 32'(a > 12'h014), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done;
    end
  end
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl mask", 32'h200f, rd);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h12345678);
    apb(1'b0, 12'h004, 32'h0);
    chk("primary", 32'h5678, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("clear reg", 32'h0, rd);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h008, 32'h8);
    apb(1'b1, 12'h014, 32'h7);
  endtask
  task automatic t_run(input logic [15:0] ctl, input int passes, input int expRise,
      input logic expPad, input logic [2:0] expStat);
    int rises;
    logic prev;
    rises = 0;
    timeBase <= '0;
    apb(1'b1, 12'h000, {16'h0, ctl});
    apb(1'b1, 12'h010, 32'h7);
    prev = padLevel;
    for (int i = 0; i < passes * 16; i++) begin
      @(posedge core_clk);
      if (padLevel === 1'b1 && prev === 1'b0) rises++;
      prev = padLevel;
      timeBase.timerA <= ctl[3] ? 16'h0004 : 16'(i % 16);
      timeBase.timerB <= ctl[3] ? 16'(i % 16) : 16'h0004;
      timeBase.periodA <= !ctl[3] && i % 16 == 0;
      timeBase.periodB <= ctl[3] && i % 16 == 0;
    end
    chk("rises", 32'(expRise), 32'(rises));
    chk("pad", 32'(expPad), 32'(padLevel));
    apb(1'b0, 12'h00c, 32'h0);
    chk("status", 32'(expStat), rd);
    chk("irq", 32'(expStat != 3'h0), 32'(irq));
  endtask
  task automatic t_fault;
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b1, 12'h010, 32'h7);
    faultReqB <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("pad b", 32'h1, 32'(padLevel));
    faultReqA <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("pad a", 32'h0, 32'(padLevel));
    apb(1'b0, 12'h000, 32'h0);
    chk("flag", 32'h17, rd);
    apb(1'b0, 12'h00c, 32'h0);
    chk("fault stat", 32'h4, rd);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'b1, 12'h014, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("irq mask", 32'h0, 32'(irq));
    faultReqA <= 1'b0;
    faultReqB <= 1'b0;
    apb(1'b1, 12'h014, 32'h7);
    apb(1'b1, 12'h010, 32'h4);
    repeat (3) @(posedge core_clk);
    chk("irq clr", 32'h0, 32'(irq));
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b0, 12'h000, 32'h0);
    chk("flag clr", 32'h7, rd);
    chk("pad back", 32'h1, 32'(padLevel));
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    t_regs;
    t_run(16'h0001, 1, 1, 1'b1, 3'h3);
    t_run(16'h000b, 2, 1, 1'b1, 3'h3);
    t_run(16'h0002, 1, 0, 1'b0, 3'h3);
    t_run(16'h000c, 2, 1, 1'b0, 3'h3);
    t_run(16'h0005, 2, 2, 1'b0, 3'h3);
    t_run(16'h000e, 2, 1, 1'b0, 3'h0);
    t_run(16'h2001, 1, 0, 1'b0, 3'h0);
    t_run(16'h0000, 1, 0, 1'b0, 3'h0);
    t_fault;
    test_done;
  end
endmodule
